// ==== swr_cpu_model.sv ====
// Processor model that strobes the watchdog kick input.
`timescale 1ns/1ps
`default_nettype none
module swr_cpu_model (
    // Clock
    input  wire logic        clk,
    // Supervisor side
    input  wire logic        reset_out,
    output var  logic        watchdog_kick_n,
    // Test control
    input  wire logic        kick_en,
    input  wire logic [15:0] kick_gap
);
    logic [15:0] cnt_q = 16'h0000;
    // Strobes start only after reset lets go; five low cycles give a pulse of exactly 20 ns.
    always @(posedge clk) begin
        #1;
        cnt_q = (reset_out || !kick_en) ? 16'h0000 : cnt_q + 16'h0001;
        watchdog_kick_n = !(cnt_q + 16'h0005 > kick_gap);
        if (cnt_q >= kick_gap) cnt_q = 16'h0000;
    end
endmodule // swr_cpu_model
`default_nettype wire

// ==== swr_pkg.sv ====
// Package for the reset supervisor: timing constants, selections and carriers.
package swr_pkg;

    localparam int unsigned CLK_HZ         = 250_000_000;
    localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US     = CLK_HZ / 1_000_000;

    // Watchdog periods in milliseconds, nominal figures.
    localparam int unsigned WDOG_SHORT_MS  = 150;
    localparam int unsigned WDOG_MID_MS    = 600;
    localparam int unsigned WDOG_LONG_MS   = 1200;
    // Reset hold time in milliseconds, nominal; the least is 250 and the most 1000.
    localparam int unsigned HOLD_MS        = 600;
    localparam int unsigned HOLD_MIN_MS    = 250;
    // Manual reset low time before reset is asserted.
    localparam int unsigned MANUAL_MS      = 20;
    // Supply fail to reset latency, most and typical, in microseconds.
    localparam int unsigned FAIL_MAX_US    = 8;
    localparam int unsigned FAIL_TYP_US    = 5;

    localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_MS * CLK_PER_MS;
    localparam int unsigned WDOG_MID_CYC   = WDOG_MID_MS * CLK_PER_MS;
    localparam int unsigned WDOG_LONG_CYC  = WDOG_LONG_MS * CLK_PER_MS;
    localparam int unsigned HOLD_CYC       = HOLD_MS * CLK_PER_MS;
    localparam int unsigned MANUAL_CYC     = MANUAL_MS * CLK_PER_MS;
    localparam int unsigned FAIL_MAX_CYC   = FAIL_MAX_US * CLK_PER_US;

    localparam int unsigned CNT_W          = 32;

    // Three-level timeout select as decoded from the pin sensing.
    typedef enum logic [1:0] {
        SWR_TD_GND   = 2'h0,
        SWR_TD_OPEN  = 2'h1,
        SWR_TD_VCC   = 2'h2
    } swr_td_t;

    // Reset causes gathered together.
    typedef struct packed {
        logic supply_low;
        logic manual;
        logic watchdog;
    } swr_cause_t;

    // Complementary reset outputs.
    typedef struct packed {
        logic rst;
        logic rst_n;
    } swr_rst_t;

endpackage : swr_pkg

// ==== swr_supervisor.sv ====
// Reset supervisor: supply-low, manual reset and watchdog into held complementary resets.
// Behaviour
// RQ1: Timeout select picks a 150, 600 or 1200 ms watchdog period.
// RQ2: Processor must give a falling kick edge within the least watchdog period.
// RQ3: Missing kick edge at period end asserts both resets for the hold time.
// RQ4: Watchdog restarts a fresh period whenever resets go inactive.
// RQ5: Watchdog cannot be disabled; only falling kick edges prevent timeout.
// RQ6: Kick interval should follow the least period; onset follows the longest.
// RQ7: Manual reset low 20 ms asserts resets, held 250 ms minimum after release.
// RQ8: Manual reset is debounced and asserts resets within 20 ms of stable low.
// RQ9: After supply recovers, resets stay active for the hold time, 250 to 1000 ms.
// RQ10: Threshold select chooses the higher trip level at ground, lower at supply.
// RQ11: Supply-low assertion reaches the resets within 8 us, undelayed by debounce.
// RQ12: Resets stay asserted while supply is below threshold during power-down.
// RQ13: Active-high reset is always the exact complement of the active-low reset.
// RQ14: Unconnected manual reset input reads as released, via internal pull-up.
// RQ15: During reset the watchdog is cleared; any new cause restarts the hold.
`timescale 1ns/1ps
`default_nettype none
module swr_supervisor
    import swr_pkg::*;
#(
    parameter int unsigned WDOG_SHORT = WDOG_SHORT_CYC,
    parameter int unsigned WDOG_MID   = WDOG_MID_CYC,
    parameter int unsigned WDOG_LONG  = WDOG_LONG_CYC,
    parameter int unsigned HOLD       = HOLD_CYC,
    parameter int unsigned MANUAL     = MANUAL_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Analog front end: comparator output and pin sensing
    input  wire logic       supply_low,
    input  wire logic       threshold_select,
    input  wire logic [1:0] timeout_select,
    output var  logic       threshold_high,
    // Processor side pins
    input  wire logic       manual_reset_n,
    input  wire logic       watchdog_kick_n,
    output var  logic       reset_out,
    output var  logic       reset_out_n
);

    typedef enum logic [1:0] {
        SWR_ST_HOLD = 2'b01,
        SWR_ST_RUN  = 2'b10
    } swr_state_t;

    swr_state_t state_q;
    swr_state_t state_d;

    logic       low_lvl;
    logic [1:0] td_lvl;
    logic       manual_lvl;
    logic       kick_lvl;
    logic       kick_prev_q;
    logic       kick_fall;
    logic       hold_done;
    logic       manual_fire;
    logic       wdog_fire;
    logic       manual_low;
    logic       release_evt;
    logic       in_hold;
    swr_cause_t cause;
    swr_rst_t   rst_q;
    logic [CNT_W-1:0] wdog_len;

    // Pulled-up pin: an open input resolves high, so reset value and init are released.
    swr_sync #(.INIT(1'b1)) u_sync_manual ( // RQ14
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (manual_reset_n),
        .level   (manual_lvl)
    );

    swr_sync #(.INIT(1'b1)) u_sync_kick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (watchdog_kick_n),
        .level   (kick_lvl)
    );

    // The comparator output is asynchronous; three flops cost a few cycles of a
    // microsecond-scale fail budget, far cheaper than a metastable cause.
    swr_sync #(.INIT(1'b1)) u_sync_low ( // RQ11 RQ12
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (supply_low),
        .level   (low_lvl)
    );

    // The straps are pins as well; a select moving during a load must not give a stray length.
    swr_sync #(.INIT(1'b0)) u_sync_td0 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (timeout_select[0]),
        .level   (td_lvl[0])
    );

    swr_sync #(.INIT(1'b0)) u_sync_td1 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (timeout_select[1]),
        .level   (td_lvl[1])
    );

    // Ground selects the higher trip level for the comparator.
    assign threshold_high = !threshold_select; // RQ10

    // Watchdog length decoded from the three-level select; an illegal code takes
    // the shortest period so a fault never lengthens supervision.
    assign wdog_len = (td_lvl == SWR_TD_OPEN) ? CNT_W'(WDOG_MID) :
                      (td_lvl == SWR_TD_VCC)  ? CNT_W'(WDOG_LONG) :
                                                CNT_W'(WDOG_SHORT); // RQ1

    // Kick edge detection on the clean level only.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kick_prev_q <= 1'b1;
        end else begin
            kick_prev_q <= kick_lvl;
        end
    end

    assign kick_fall = kick_prev_q && !kick_lvl;
    assign in_hold   = (state_q == SWR_ST_HOLD);
    assign manual_low = !manual_lvl;

    // Debounce: the input must stay low a full count before it is a cause.
    swr_timer u_manual (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (manual_lvl),
        .load_val (CNT_W'(MANUAL)),
        .run      (manual_low),
        .expired  (manual_fire)
    ); // RQ7 RQ8

    // Watchdog: reloaded on a falling kick and on leaving the hold; it has no
    // enable, so only kicks keep it from expiring.
    swr_timer u_wdog (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (kick_fall || in_hold),
        .load_val (wdog_len),
        .run      (!in_hold),
        .expired  (wdog_fire)
    ); // RQ4 RQ5 RQ15

    // A manual cause stays in force while the input is low past its debounce.
    logic manual_hold_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            manual_hold_q <= 1'b0;
        end else if (manual_lvl) begin
            manual_hold_q <= 1'b0;
        end else if (manual_fire) begin
            manual_hold_q <= 1'b1;
        end
    end

    assign cause.supply_low = low_lvl;
    assign cause.manual     = manual_fire || manual_hold_q;
    assign cause.watchdog   = wdog_fire; // RQ3

    // Any active cause reloads the hold, so the hold counts from the last cause.
    assign release_evt = |cause; // RQ15

    swr_timer u_hold (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (release_evt),
        .load_val (CNT_W'(HOLD)),
        .run      (in_hold),
        .expired  (hold_done)
    ); // RQ9 RQ7

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SWR_ST_HOLD: begin
                if (hold_done) begin
                    state_d = SWR_ST_RUN;
                end
            end
            SWR_ST_RUN: begin
                if (release_evt) begin
                    state_d = SWR_ST_HOLD; // RQ3 RQ11
                end
            end
            default: begin
                state_d = SWR_ST_HOLD;
            end
        endcase
    end

    // Power-on behaves as a supply recovery: reset is active out of reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= SWR_ST_HOLD;
            rst_q   <= '{rst: 1'b1, rst_n: 1'b0};
        end else begin
            state_q   <= state_d;
            rst_q.rst <= (state_d == SWR_ST_HOLD);
            rst_q.rst_n <= !(state_d == SWR_ST_HOLD); // RQ13
        end
    end

    assign reset_out   = rst_q.rst;
    assign reset_out_n = rst_q.rst_n;

endmodule // swr_supervisor
`default_nettype wire

// ==== swr_supervisor_chk.sv ====
// Assertion checker for the reset supervisor ports.
`timescale 1ns/1ps
`default_nettype none
module swr_supervisor_chk
    import swr_pkg::*;
#(
    parameter int unsigned WDOG_SHORT = WDOG_SHORT_CYC,
    parameter int unsigned WDOG_MID   = WDOG_MID_CYC,
    parameter int unsigned WDOG_LONG  = WDOG_LONG_CYC,
    parameter int unsigned HOLD       = HOLD_CYC,
    parameter int unsigned MANUAL     = MANUAL_CYC
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Front end
    input wire logic       supply_low,
    input wire logic       threshold_select,
    input wire logic [1:0] timeout_select,
    input wire logic       threshold_high,
    // Processor side
    input wire logic       manual_reset_n,
    input wire logic       watchdog_kick_n,
    input wire logic       reset_out,
    input wire logic       reset_out_n
);
    // Run lengths in cycles; the margins allow for input synchronisers.
    logic [31:0] hi_q;
    logic [31:0] wd_q;
    logic [31:0] man_q;
    wire  [31:0] lim = (timeout_select == 2'h1) ? WDOG_MID :
                       (timeout_select == 2'h2) ? WDOG_LONG : WDOG_SHORT;
    always_ff @(posedge clk) begin
        hi_q  <= (sys_rst || !reset_out) ? '0 : hi_q + 1'h1;
        wd_q  <= (sys_rst || reset_out || $fell(watchdog_kick_n)) ? '0 : wd_q + 1'h1;
        man_q <= (sys_rst || manual_reset_n) ? '0 : man_q + 1'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_fail; $rose(supply_low); endsequence
    sequence s_back; $fell(supply_low) ##0 reset_out; endsequence
    property p_compl; reset_out_n == !reset_out; endproperty
    a_compl: assert property (p_compl) else $error("outputs not complementary");
    property p_thr; threshold_high == !threshold_select; endproperty
    a_thr: assert property (p_thr) else $error("threshold level wrong");
    property p_fail; s_fail |-> ##[1:6] reset_out; endproperty
    a_fail: assert property (p_fail) else $error("supply fail reset late");
    property p_low; supply_low [*6] |-> reset_out; endproperty
    a_low: assert property (p_low) else $error("reset dropped at low supply");
    property p_back; s_back |=> reset_out [*8]; endproperty
    a_back: assert property (p_back) else $error("reset not held on recovery");
    property p_min; $fell(reset_out) |-> hi_q >= HOLD; endproperty
    a_min: assert property (p_min) else $error("reset hold too short");
    property p_wd; wd_q <= lim + 10; endproperty
    a_wd: assert property (p_wd) else $error("watchdog timeout missed");
    property p_man; man_q == MANUAL + 12 |-> reset_out; endproperty
    a_man: assert property (p_man) else $error("manual reset missed");
endmodule // swr_supervisor_chk

bind swr_supervisor swr_supervisor_chk #(.WDOG_SHORT(WDOG_SHORT), .WDOG_MID(WDOG_MID),
    .WDOG_LONG(WDOG_LONG), .HOLD(HOLD), .MANUAL(MANUAL)) u_swr_supervisor_chk (.clk(clk),
    .sys_rst(sys_rst), .supply_low(supply_low), .threshold_select(threshold_select),
    .timeout_select(timeout_select), .threshold_high(threshold_high),
    .manual_reset_n(manual_reset_n), .watchdog_kick_n(watchdog_kick_n),
    .reset_out(reset_out), .reset_out_n(reset_out_n));
`default_nettype wire

// ==== swr_supervisor_tb.sv ====
// Self-checking bench for the reset supervisor.
`timescale 1ns/1ps
`default_nettype none
module swr_supervisor_tb import swr_pkg::*; ();
    localparam int WS = 200, WM = 400, WL = 800, HD = 100, MN = 50;
    logic       clk, sys_rst, supply_low, threshold_select, manual_reset_n, kick_en;
    logic [1:0] timeout_select;
    logic [15:0] kick_gap;
    wire logic  threshold_high, reset_out, reset_out_n, watchdog_kick_n;
    int mismatches = 0, total_checks = 0, hi_cnt = 0, d, k, len;
    int exp_q[$];
    swr_supervisor #(.WDOG_SHORT(WS), .WDOG_MID(WM), .WDOG_LONG(WL), .HOLD(HD), .MANUAL(MN))
        u_swr_supervisor (.clk(clk), .sys_rst(sys_rst), .supply_low(supply_low),
        .threshold_select(threshold_select), .timeout_select(timeout_select),
        .threshold_high(threshold_high), .manual_reset_n(manual_reset_n),
        .watchdog_kick_n(watchdog_kick_n), .reset_out(reset_out), .reset_out_n(reset_out_n));
    swr_cpu_model u_swr_cpu_model (.clk(clk), .reset_out(reset_out),
        .watchdog_kick_n(watchdog_kick_n), .kick_en(kick_en), .kick_gap(kick_gap));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        tick(8);
        while (reset_out !== 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        check(reset_out === 1'b0, "reset stuck");
        check(reset_out_n === 1'b1, "reset pair low");
        tick(5);
    endtask
    // Each noted cause length plus the hold gives the expected reset length.
    always @(posedge clk) begin
        if (reset_out === 1'b1) hi_cnt++;
        else if (hi_cnt > 0) begin
            if (exp_q.size() == 0) check(1'b0, "reset without cause");
            else begin
                len = exp_q.pop_front() + HD;
                check(hi_cnt >= len - 8 && hi_cnt <= len + 12, "reset length");
            end
            hi_cnt = 0;
        end
    end
    initial begin
        tick(30000);
        mismatches++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        supply_low = 1'b0;
        threshold_select = 1'b0;
        manual_reset_n = 1'b1;
        timeout_select = 2'h0;
        kick_en = 1'b1;
        kick_gap = 16'h0050;
        void'($urandom(94));
        exp_q.push_back(10);
        tick(10);
        sys_rst = 1'b0;
        wait_idle();
        for (int i = 0; i < 2; i++) begin
            threshold_select = i[0];
            tick(1);
            check(threshold_high === ~threshold_select, "threshold");
        end
        repeat (3) begin
            d = $urandom_range(40, 4);
            exp_q.push_back(d);
            supply_low = 1'b1;
            tick(d);
            supply_low = 1'b0;
            wait_idle();
        end
        manual_reset_n = 1'b0;
        tick(MN - 10);
        manual_reset_n = 1'b1;
        tick(40);
        check(reset_out === 1'b0, "short press reset");
        d = MN + $urandom_range(60, 20);
        exp_q.push_back(d - MN);
        manual_reset_n = 1'b0;
        tick(d);
        manual_reset_n = 1'b1;
        wait_idle();
        for (int t = 0; t < 4; t++) begin
            timeout_select = t[1:0];
            k = (t == 1) ? WM : (t == 2) ? WL : WS;
            kick_gap = 16'($urandom_range(150, 20));
            tick(3 * WL);
            check(reset_out === 1'b0, "kicked watchdog fired");
            @(negedge watchdog_kick_n);
            tick(6);
            kick_en = 1'b0;
            exp_q.push_back(t == 3 ? 40 : 0);
            tick(k - 12);
            check(reset_out === 1'b0, "watchdog early");
            d = 0;
            while (reset_out !== 1'b1 && d < 30) begin
                tick(1);
                d++;
            end
            check(reset_out === 1'b1, "watchdog missed");
            check(reset_out_n === 1'b0, "reset pair high");
            kick_en = 1'b1;
            if (t == 3) begin
                tick(30);
                supply_low = 1'b1;
                tick(10);
                supply_low = 1'b0;
            end
            wait_idle();
        end
        check(exp_q.size() == 0, "missing reset");
        give_verdict();
    end
endmodule // swr_supervisor_tb
`default_nettype wire

// ==== swr_sync.sv ====
// Three-stage input synchroniser with agreement on the last two stages.
`timescale 1ns/1ps
`default_nettype none
module swr_sync
    import swr_pkg::*;
#(
    parameter logic INIT = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Pin and clean level
    input  wire logic pin,
    output var  logic level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // A change counts only when the second and third stages agree.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            lvl_q <= INIT;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end

    assign level = lvl_q;

endmodule // swr_sync
`default_nettype wire

// ==== swr_timer.sv ====
// Loadable down-counter that flags when it reaches zero.
`timescale 1ns/1ps
`default_nettype none
module swr_timer
    import swr_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    input  wire logic             run,
    // Status
    output var  logic             expired
);

    logic [CNT_W-1:0] cnt_q;

    // Load wins over counting so a restart always begins a full period.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (run && cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    assign expired = run && !load && (cnt_q == '0);

endmodule // swr_timer
`default_nettype wire
